// ### src/battery_protection_arbiter.sv
`timescale 1ns/1ps
`include "batt_prot_consts.svh"

// Overview of operation
// - zero-volt charger turns charge drive on
// - zero-volt charging ends when cells recover
// - reverse charger drops discharge drive immediately
// - over-charge priority; delayed discharge off, no standby
// - over-charge and discharge over-current run parallel
// - over-charge first cancels discharge over-current 1/2
// - under-voltage after over-current: pull-up, standby
// - under-voltage first: pull-up, standby
// - charge over-current then under-voltage: no standby
// - under-voltage cancels charge over-current detection
// - over-charge during over-current also drops charge
// - standby once load sense is pulled up
// - normal state holds both drives high
module battery_protection_arbiter
    import batt_prot_pkg::*;
#(
    parameter int T_OC   = `CYC(`T_OC_US),
    parameter int T_OCR  = `CYC(`T_OCR_US),
    parameter int T_OD   = `CYC(`T_OD_US),
    parameter int T_ODR  = `CYC(`T_ODR_US),
    parameter int T_DOC1 = `CYC(`T_DOC1_US),
    parameter int T_DOC2 = `CYC(`T_DOC2_US),
    parameter int T_SH   = `CYC(`T_SH_US),
    parameter int T_CC   = `CYC(`T_CC_US),
    parameter int T_CCR  = `CYC(`T_CCR_US),
    parameter int T_ZV   = `CYC(`T_ZV_US)
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // comparator inputs
    input  wire batt_prot_pkg::sense_t  sense,
    // fet gates and load-sense switches
    output batt_prot_pkg::drive_t       drive
);
    import batt_prot_pkg::*;

    localparam int W = `CNT_W;

    function automatic logic [W-1:0] lim(input int c);
        lim = (c < 1) ? W'(1) : W'(c);
    endfunction

    logic    oc_fix_q, od_fix_q, cc_fix_q, doc_fix_q, zv_q;
    logic    chg_q, dis_q, pu_q, pd_q;
    logic    pend_od_q;
    dstate_t st_q;
    logic    stby;
    logic    oc_done, ocr_done, od_done, odr_done, doc1_done, doc2_done;
    logic    sh_done, cc_done, ccr_done, zv_done;

    assign stby = (st_q == DS_STBY);

    // all counters freeze in standby
    fault_delay #(.W(W)) u_oc (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(sense.over_charge), .freeze(stby), .clear(oc_fix_q),
        .limit(lim(T_OC)), .done(oc_done));
    fault_delay #(.W(W)) u_ocr (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(sense.below_release), .freeze(stby), .clear(!oc_fix_q),
        .limit(lim(T_OCR)), .done(ocr_done));
    // under-voltage count runs even after over-charge is fixed
    fault_delay #(.W(W)) u_od (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(sense.under_volt), .freeze(stby), .clear(od_fix_q),
        .limit(lim(T_OD)), .done(od_done));
    fault_delay #(.W(W)) u_odr (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(!sense.under_volt && sense.charger), .freeze(stby),
        .clear(!od_fix_q), .limit(lim(T_ODR)), .done(odr_done));
    // over-charge fixed cancels pending over-current 1/2
    fault_delay #(.W(W)) u_doc1 (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(sense.discharge_oc1), .freeze(stby), .clear(oc_fix_q || doc_fix_q),
        .limit(lim(T_DOC1)), .done(doc1_done));
    fault_delay #(.W(W)) u_doc2 (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(sense.discharge_oc2), .freeze(stby), .clear(oc_fix_q || doc_fix_q),
        .limit(lim(T_DOC2)), .done(doc2_done));
    fault_delay #(.W(W)) u_sh (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(sense.short_ckt), .freeze(stby), .clear(doc_fix_q),
        .limit(lim(T_SH)), .done(sh_done));
    // charge over-current cancelled while under-voltage fixed
    fault_delay #(.W(W)) u_cc (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(sense.charge_oc), .freeze(stby), .clear(od_fix_q || cc_fix_q),
        .limit(lim(T_CC)), .done(cc_done));
    fault_delay #(.W(W)) u_ccr (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(!sense.charge_oc), .freeze(stby), .clear(!cc_fix_q),
        .limit(lim(T_CCR)), .done(ccr_done));
    fault_delay #(.W(W)) u_zv (.ref_clk(ref_clk), .rst_n(rst_n),
        .cond(sense.zero_volt_ok && sense.cell_zero), .freeze(stby),
        .clear(zv_q), .limit(lim(T_ZV)), .done(zv_done));

    // over-charge state; may fix during over-current too
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_fix_q <= 1'b0;
        end else if (oc_done) begin
            oc_fix_q <= 1'b1;
        end else if (ocr_done) begin
            oc_fix_q <= 1'b0;
        end
    end

    // under-voltage state, released only with a charger
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            od_fix_q <= 1'b0;
        end else if (od_done) begin
            od_fix_q <= 1'b1;
        end else if (odr_done) begin
            od_fix_q <= 1'b0;
        end
    end

    // charge over-current state; fixed state outlives under-voltage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cc_fix_q <= 1'b0;
        end else if (cc_done) begin
            cc_fix_q <= 1'b1;
        end else if (ccr_done) begin
            cc_fix_q <= 1'b0;
        end
    end

    // discharge over-current state; released when load is detached
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            doc_fix_q <= 1'b0;
        end else if (doc1_done || doc2_done || sh_done) begin
            doc_fix_q <= 1'b1;
        end else if (sense.load_low && !sense.discharge_oc1 && !stby) begin
            doc_fix_q <= 1'b0;
        end
    end

    // zero-volt charging path
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zv_q <= 1'b0;
        end else if (zv_done) begin
            zv_q <= 1'b1;
        end else if (!sense.under_volt || !sense.zero_volt_ok) begin
            zv_q <= 1'b0;
        end
    end

    // pull-up waiting for node to rise before standby
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_od_q <= 1'b0;
        end else begin
            pend_od_q <= od_fix_q && !oc_fix_q && !cc_fix_q && !sense.charger;
        end
    end

    // standby sequencing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= DS_NORMAL;
        end else begin
            unique case (st_q)
                DS_NORMAL: begin
                    if (od_fix_q || doc_fix_q) begin
                        st_q <= DS_TRIP;
                    end
                end
                DS_TRIP: begin
                    if (pend_od_q && !oc_fix_q && sense.reverse == 1'b0 && !sense.load_low) begin
                        st_q <= DS_STBY;
                    end else if (!od_fix_q && !doc_fix_q) begin
                        st_q <= DS_NORMAL;
                    end
                end
                DS_STBY: begin
                    if (sense.charger) begin
                        st_q <= DS_TRIP;
                    end
                end
            endcase
        end
    end

    // gate drives; normal state holds both high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_q <= 1'b0;
            dis_q <= 1'b0;
        end else begin
            chg_q <= zv_q || !(oc_fix_q || cc_fix_q || (od_fix_q && !sense.charger));
            dis_q <= !(od_fix_q || doc_fix_q || sense.reverse);
        end
    end

    // load-sense switches: pull-up on under-voltage wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            pu_q <= od_fix_q;
            pd_q <= doc_fix_q && !od_fix_q;
        end
    end

    // reverse charge bypasses the delay and register
    assign drive.charge_fet_drive    = chg_q;
    assign drive.discharge_fet_drive = dis_q && !sense.reverse;
    assign drive.pull_up_en          = pu_q;
    assign drive.pull_down_en        = pd_q;
    assign drive.standby             = stby;

    a_reverse_fast: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sense.reverse |-> !drive.discharge_fet_drive)
        else $error("discharge drive high during reverse charge");

    a_oc_drops_chg: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (oc_fix_q && !zv_q) |=> !drive.charge_fet_drive)
        else $error("charge drive high with over-charge fixed");

    a_oc_no_stby: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (oc_fix_q && st_q == DS_TRIP) |=> st_q != DS_STBY)
        else $error("standby entered under over-charge");

    a_od_cancels_cc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (od_fix_q && !cc_fix_q) |=> !cc_fix_q)
        else $error("charge over-current kept during under-voltage");

    a_normal_drives: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n && !oc_fix_q && !od_fix_q && !cc_fix_q && !doc_fix_q && !sense.reverse)
        |-> drive.charge_fet_drive && dis_q)
        else $error("drives low in normal state");

    a_od_pullup: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (od_fix_q && doc_fix_q) |=> !drive.pull_down_en)
        else $error("pull-down left on after under-voltage");

    a_stby_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (stby && !sense.charger) |=> stby)
        else $error("left standby without a charger");

    a_zv_chg: assert property (@(posedge ref_clk) disable iff (!rst_n)
        zv_q |=> drive.charge_fet_drive)
        else $error("charge drive off during zero-volt charging");

endmodule // battery_protection_arbiter

// ### src/batt_prot_consts.svh
`ifndef BATT_PROT_CONSTS_SVH
`define BATT_PROT_CONSTS_SVH

// clock period in ns (40 MHz)
`define CLK_PERIOD_NS      25
// delay times in microseconds, as defaults
`define T_OC_US            1000
`define T_OCR_US           16
`define T_OD_US            1000
`define T_ODR_US           1
`define T_DOC1_US          500
`define T_DOC2_US          10
`define T_SH_US            1
`define T_CC_US            200
`define T_CCR_US           1
`define T_ZV_US            1
// cycle counts derived from the times (least times round up)
`define CYC(us) ((((us) * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              16

`endif

// ### src/batt_prot_pkg.sv
package batt_prot_pkg;

    // comparator levels from the analog front end
    typedef struct packed {
        logic over_charge;     // a cell at or above over-charge level
        logic below_release;   // both cells below release level
        logic under_volt;      // a cell at or below over-discharge level
        logic charge_oc;       // load sense below charge over-current level
        logic discharge_oc1;   // load sense in over-current 1 band
        logic discharge_oc2;   // load sense in over-current 2 band
        logic short_ckt;       // load sense at or above short level
        logic load_low;        // load sense below over-current 1 level
        logic reverse;         // load sense above supply plus margin
        logic charger;         // charger present
        logic zero_volt_ok;    // charger at or above zero_volt_charge_threshold
        logic cell_zero;       // a cell below usable level (depleted)
    } sense_t;

    typedef struct packed {
        logic charge_fet_drive;
        logic discharge_fet_drive;
        logic pull_up_en;
        logic pull_down_en;
        logic standby;
    } drive_t;

    typedef enum logic [2:0] {
        DS_NORMAL = 3'b001,
        DS_TRIP   = 3'b010,
        DS_STBY   = 3'b100
    } dstate_t;

endpackage

// ### src/fault_delay.sv
`timescale 1ns/1ps
`include "batt_prot_consts.svh"

module fault_delay #(
    parameter int W = `CNT_W
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         cond,
    input  wire logic         freeze,
    input  wire logic         clear,
    input  wire logic [W-1:0] limit,
    // result
    output logic              done
);
    logic [W-1:0] cnt_q;

    // counter restarts when the condition drops early
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clear || !cond) begin
            cnt_q <= '0;
        end else if (!freeze && cnt_q < limit) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign done = cond && !clear && (cnt_q >= limit);

endmodule // fault_delay

// ### tb/fet_load_model.sv
`timescale 1ns/1ps

module fet_load_model
    import batt_prot_pkg::*;
(
    // gates and switches from the block
    input  wire batt_prot_pkg::drive_t drive,
    // external conditions
    input  wire logic                  charger,
    input  wire logic                  ext_low,
    // load-sense comparator level
    output logic                       load_low
);
    // pull-up lifts the node unless a charger drags it below ground
    assign load_low = (drive.pull_up_en && !charger) ? 1'b0 : ext_low;
endmodule // fet_load_model

// ### tb/battery_protection_arbiter_tb.sv
`timescale 1ns/1ps

module battery_protection_arbiter_tb;
    import batt_prot_pkg::*;
    localparam int T = 4;
    typedef struct {
        logic [11:0] a;
        logic [11:0] b;
        logic [4:0]  exp;
        logic [4:0]  msk;
    } row_t;
    logic        ref_clk     = 1'b0;
    logic        rst_n       = 1'b0;
    logic [11:0] stim        = 12'h410;
    logic        ld_low;
    sense_t      sense;
    drive_t      drive;
    int          n_mismatch  = 0;
    int          check_count = 0;
    // first and second condition, expected drive, compared bits
    row_t        rows [12]   = '{
        '{12'h410, 12'h410, 5'h18, 5'h1F},
        '{12'h480, 12'h480, 5'h12, 5'h1F},
        '{12'h440, 12'h440, 5'h12, 5'h1F},
        '{12'h480, 12'h880, 5'h02, 5'h1F},
        '{12'h810, 12'h880, 5'h08, 5'h1F},
        '{12'h600, 12'h600, 5'h05, 5'h0F},
        '{12'h480, 12'h680, 5'h05, 5'h0F},
        '{12'h514, 12'h714, 5'h04, 5'h1D},
        '{12'h810, 12'hA10, 5'h04, 5'h1D},
        '{12'h617, 12'h617, 5'h10, 5'h10},
        '{12'h617, 12'h414, 5'h18, 5'h1F},
        '{12'h604, 12'h704, 5'h14, 5'h1D}
    };

    always #12.5 ref_clk = ~ref_clk;

    assign sense = {stim[11:5], ld_low, stim[3:0]};

    fet_load_model i_far (
        .drive   (drive),
        .charger (stim[2]),
        .ext_low (stim[4]),
        .load_low(ld_low)
    );

    battery_protection_arbiter #(
        .T_OC(T), .T_OCR(T), .T_OD(T), .T_ODR(T), .T_DOC1(T),
        .T_DOC2(T), .T_SH(T), .T_CC(T), .T_CCR(T), .T_ZV(T)
    ) i_dut (
        .ref_clk(ref_clk),
        .rst_n  (rst_n),
        .sense  (sense),
        .drive  (drive)
    );

    task automatic chk(input string what, input drive_t got, input logic [4:0] exp,
                       input logic [4:0] msk);
        check_count++;
        if ((got & msk) !== (exp & msk)) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp & msk, got & msk);
        end
    endtask

    task automatic wait_for(input logic [4:0] exp, input logic [4:0] msk, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge ref_clk);
            if ((drive & msk) === exp) begin
                break;
            end
        end
        chk("drive after wait", drive, exp, msk);
        // a wait that ran out ends the run at once
        if ((drive & msk) !== exp) begin
            give_verdict();
        end
    endtask

    task automatic run_row(input row_t r);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        stim  <= r.a;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge ref_clk);
        stim <= r.b;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (11) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("drive in reset", drive, 5'h00, 5'h1F);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("drive after reset", drive, 5'h18, 5'h1F);
        $display("test reset done");
        foreach (rows[r]) begin
            run_row(rows[r]);
            chk("drive in row", drive, rows[r].exp, rows[r].msk);
            $display("test row %0d done", r);
        end
        // reverse charger must cut discharge in the same cycle
        run_row(rows[0]);
        @(posedge ref_clk);
        stim <= 12'h418;
        @(negedge ref_clk);
        chk("discharge on reverse", drive, 5'h00, 5'h08);
        @(posedge ref_clk);
        stim <= 12'h410;
        $display("test reverse done");
        // short over-current pulses never reach the limit
        for (int k = 0; k < 6; k++) begin
            @(posedge ref_clk);
            stim <= 12'h480;
            repeat (T - 2) @(posedge ref_clk);
            stim <= 12'h410;
        end
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("discharge after pulses", drive, 5'h08, 5'h08);
        $display("test restart done");
        // standby woken by a charger, then over-discharge released
        run_row(rows[5]);
        @(posedge ref_clk);
        stim <= 12'h604;
        wait_for(5'h00, 5'h01, 5);
        @(posedge ref_clk);
        stim <= 12'h414;
        wait_for(5'h08, 5'h08, 30);
        $display("test wake done");
        give_verdict();
    end
endmodule // battery_protection_arbiter_tb
